// ---- bench/cbr_core_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module cbr_core_regs_asserts
  import cbr_pkg::*;
(
  // clock and reset
  input wire logic                mclk,
  input wire logic                rst_n,
  // stimulus seen by the block
  input wire logic                warmReset,
  input wire logic                warmTo,
  input wire logic                warmPd,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire cbr_pkg::cbr_paddr_t paddr,
  input wire cbr_pkg::cbr_word_t  pwdata,
  input wire logic [3:0]          pstrb,
  // answers of the block
  input wire cbr_pkg::cbr_word_t  prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire cbr_pkg::cbr_byte_t  pcLow,
  input wire logic [6:0]          pcHighLatch,
  input wire logic [4:0]          bankSel,
  input wire cbr_pkg::cbr_byte_t  workAcc,
  input wire cbr_pkg::cbr_byte_t  intCtrl,
  input wire logic [4:0]          coreFlags,
  input wire cbr_pkg::cbr_ptr_t   ptrZero,
  input wire cbr_pkg::cbr_ptr_t   ptrOne
);
  // warm reset beats a write, so it is excluded here
  wire logic       wrOk = psel & penable & pwrite & pstrb[0] &
                          (paddr[1:0] == 2'b00) & !warmReset;
  wire logic [6:0] idx  = paddr[8:2];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_latch_wr;
    wrOk && idx == 7'h0a |=> pcHighLatch == $past(pwdata[6:0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr)
    else $error("latch write lost");
  property p_mirror;
    wrOk && idx == 7'h09 |=> workAcc == $past(pwdata[7:0]);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("accumulator not reached from this bank");
  property p_hole;
    psel && !penable && !pwrite && idx >= 7'h0c |=> prdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole)
    else $error("empty location read nonzero");
  property p_misalign;
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned access without error");
  property p_warm_clr;
    warmReset |=> pcLow == 8'h00 && pcHighLatch == 7'h00 && bankSel == 5'h00
      && intCtrl == 8'h00 && ptrZero[15:8] == 8'h00 && ptrOne[15:8] == 8'h00
      && coreFlags[4:3] == {$past(warmTo), $past(warmPd)};
  endproperty
  a_warm_clr: assert property (p_warm_clr)
    else $error("warm reset left a register uncleared");
  property p_warm_keep;
    warmReset |=> workAcc == $past(workAcc)
      && ptrZero[7:0] == $past(ptrZero[7:0])
      && ptrOne[7:0] == $past(ptrOne[7:0]);
  endproperty
  a_warm_keep: assert property (p_warm_keep)
    else $error("warm reset changed a kept register");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase stalled");
  c_latch: cover property (wrOk && idx == 7'h0a);
  c_warm: cover property (warmReset);
  c_window: cover property (psel && penable && !pwrite && idx == 7'h01);
endmodule // cbr_core_regs_asserts
bind cbr_core_regs cbr_core_regs_asserts i_chk (.mclk, .rst_n, .warmReset,
  .warmTo, .warmPd, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .pcLow, .pcHighLatch, .bankSel, .workAcc,
  .intCtrl, .coreFlags, .ptrZero, .ptrOne);
`default_nettype wire

// ---- bench/test_cbr_core_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_cbr_core_regs;
  import cbr_pkg::*;
  logic       mclk      = 1'b0;
  logic       rst_n     = 1'b0;
  logic       warmReset = 1'b0;
  logic       warmTo    = 1'b0;
  logic       warmPd    = 1'b0;
  logic       psel      = 1'b0;
  logic       penable   = 1'b0;
  logic       pwrite    = 1'b0;
  cbr_paddr_t paddr     = '0;
  cbr_word_t  pwdata    = '0;
  logic [3:0] pstrb     = 4'h1;
  cbr_word_t  prdata;
  logic       pready;
  logic       pslverr;
  logic [6:0] pch;
  cbr_byte_t  rd;
  logic       err;
  int         bad_count = 0;
  int         compares  = 0;
  // expected: after reset, after all-ones writes, after warm reset
  cbr_byte_t  ex [3][2:12] = '{
    '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h1f, 8'hff, 8'h7f, 8'hff, 8'h00},
    '{8'h00, 8'h0f, 8'hff, 8'h00, 8'hff, 8'h00,
      8'h00, 8'hff, 8'h00, 8'h00, 8'h00}};
  // lane zero strobe is driven so a strobeless write can be tried
  cbr_core_regs i_dut (.mclk, .rst_n, .warmReset, .warmTo, .warmPd, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pcLow(), .pcHighLatch(pch), .bankSel(), .workAcc(),
    .intCtrl(), .coreFlags(), .ptrZero(), .ptrOne());
  always #10 mclk = ~mclk;
  function automatic cbr_paddr_t pa(input int bank, input int idx);
    pa = cbr_paddr_t'((bank * 128 + idx) * 4);
  endfunction
  // one apb transfer; idle edge first so strobes never toggle twice
  task automatic xfer(input cbr_paddr_t a, input logic w,
                      input cbr_byte_t d);
    @(posedge mclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input cbr_byte_t e,
                     input cbr_byte_t g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 2; i < 13; i++)
    begin
      xfer(pa(7, i), 1'b0, 8'h00);
      chk("reset value", ex[0][i], rd);
    end
    for (int i = 2; i < 13; i++)
      xfer(pa(3, i), 1'b1, 8'hff);
    for (int i = 2; i < 13; i++)
    begin
      xfer(pa(0, i), 1'b0, 8'h00);
      chk("mirrored", ex[1][i], rd);
    end
    chk("latch port", 8'h7f, {1'b0, pch});
    xfer(pa(0, 9) | 14'h2, 1'b1, 8'h11);
    chk("misaligned error", 8'h01, {7'h00, err});
    xfer(pa(0, 9) | 14'h1, 1'b0, 8'h00);
    chk("misaligned read", 8'h00, rd);
    warmPd    <= 1'b1;
    warmReset <= 1'b1;
    @(posedge mclk);
    warmReset <= 1'b0;
    for (int i = 2; i < 13; i++)
    begin
      xfer(pa(30, i), 1'b0, 8'h00);
      chk("warm reset", ex[2][i], rd);
    end
    // a write without the lane zero strobe is ignored
    pstrb <= 4'h0;
    xfer(pa(5, 9), 1'b1, 8'h22);
    pstrb <= 4'h1;
    xfer(pa(6, 9), 1'b0, 8'h00);
    chk("strobeless write", 8'hff, rd);
    // both pointers aim at one data location
    xfer(pa(1, 5), 1'b1, 8'h02);
    xfer(pa(1, 4), 1'b1, 8'h34);
    xfer(pa(2, 7), 1'b1, 8'h02);
    xfer(pa(2, 6), 1'b1, 8'h34);
    xfer(pa(4, 0), 1'b1, 8'h5a);
    xfer(pa(9, 1), 1'b0, 8'h00);
    chk("window", 8'h5a, rd);
    chk("aligned error", 8'h00, {7'h00, err});
    xfer(pa(0, 7), 1'b1, 8'h10);
    xfer(pa(0, 1), 1'b0, 8'h00);
    chk("far window", 8'h00, rd);
    print_verdict();
  end
  // watchdog against a hung transfer
  initial
  begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end
endmodule // test_cbr_core_regs
`default_nettype wire

// ---- hw/cbr_core_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cbr_regs.svh"
module cbr_core_regs (
  // clock and power-on reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // warm reset from the reset controller, same clock
  input  wire logic        warmReset,
  input  wire logic        warmTo,
  input  wire logic        warmPd,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire cbr_pkg::cbr_paddr_t paddr,
  input  wire cbr_pkg::cbr_word_t  pwdata,
  input  wire logic [3:0]  pstrb,
  output var  cbr_pkg::cbr_word_t  prdata,
  output logic             pready,
  output logic             pslverr,
  // register contents for the core
  output var  cbr_pkg::cbr_byte_t  pcLow,
  output logic [6:0]       pcHighLatch,
  output logic [4:0]       bankSel,
  output var  cbr_pkg::cbr_byte_t  workAcc,
  output var  cbr_pkg::cbr_byte_t  intCtrl,
  output logic [4:0]       coreFlags,
  output var  cbr_pkg::cbr_ptr_t   ptrZero,
  output var  cbr_pkg::cbr_ptr_t   ptrOne
);
  import cbr_pkg::*;

  // reset release synchroniser
  // assertion stays asynchronous so reset works with the clock stopped;
  // release is synchronised so every register leaves reset on one edge
  logic rstMeta_q;
  logic rstSync_q;
  wire  rstN;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  assign rstN = rstSync_q;

  // register state
  // one byte each except the prdata_q word; only the implemented bits ever become nonzero
  cbr_byte_t  pcl_q;
  cbr_byte_t  flags_q;
  cbr_byte_t  p0Lo_q;
  cbr_byte_t  p0Hi_q;
  cbr_byte_t  p1Lo_q;
  cbr_byte_t  p1Hi_q;
  cbr_byte_t  bank_q;
  cbr_byte_t  wacc_q;
  cbr_byte_t  pch_q;
  cbr_byte_t  intc_q;
  cbr_word_t  prdata_q;

  // data memory behind the windows
  // the store has no reset: its bytes are unknown until first written
  cbr_mem_if  memBus ();

  cbr_data_mem uMem (
    .mclk (mclk),
    .mem  (memBus)
  );

  // apb phase decode
  // no wait states: the access phase always ends on its first edge
  wire        setupPh;
  wire        accessPh;
  wire        aligned;
  cbr_daddr_t dataAddr;
  wire [6:0]  bankOff;
  wire        coreHit;
  wire        wrCore;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign aligned  = (paddr[1:0] == 2'b00);
  assign dataAddr = paddr[13:2];
  // bank bits ignored
  // only the offset within a bank selects, so all 32 banks alias
  assign bankOff  = dataAddr[6:0];
  assign coreHit  = (bankOff < `CBR_CORE_COUNT);
  // writes outside ignored
  // strobe for the low lane is required, other lanes carry nothing
  // a write with the low strobe clear is dropped without an error
  assign wrCore   = accessPh & pwrite & aligned & pstrb[0] & coreHit;

  // per-register write enables
  // each enable already holds access phase, alignment and lane zero
  wire wePcl;
  wire weFlags;
  wire weP0Lo;
  wire weP0Hi;
  wire weP1Lo;
  wire weP1Hi;
  wire weBank;
  wire weWacc;
  wire wePch;
  wire weIntc;
  wire weWin;

  assign wePcl   = wrCore & (bankOff == `CBR_IDX_PCL);
  assign weFlags = wrCore & (bankOff == `CBR_IDX_FLAGS);
  assign weP0Lo  = wrCore & (bankOff == `CBR_IDX_P0LO);
  assign weP0Hi  = wrCore & (bankOff == `CBR_IDX_P0HI);
  assign weP1Lo  = wrCore & (bankOff == `CBR_IDX_P1LO);
  assign weP1Hi  = wrCore & (bankOff == `CBR_IDX_P1HI);
  assign weBank  = wrCore & (bankOff == `CBR_IDX_BANK);
  assign weWacc  = wrCore & (bankOff == `CBR_IDX_WACC);
  assign wePch   = wrCore & (bankOff == `CBR_IDX_PCH);
  assign weIntc  = wrCore & (bankOff == `CBR_IDX_INTC);

  // window redirection
  // limitation: a pointer aimed at the core group reaches plain memory,
  // not the registers, so software cannot loop a window back on itself
  wire      selWin0;
  wire      selWin1;
  cbr_ptr_t winPtr;
  wire      winReach;

  assign selWin0  = (bankOff == `CBR_IDX_WIN0);
  assign selWin1  = (bankOff == `CBR_IDX_WIN1);
  assign winPtr   = selWin1 ? {p1Hi_q, p1Lo_q} : {p0Hi_q, p0Lo_q};
  // pointers past the 4 KiB space reach nothing
  assign winReach = (winPtr[15:12] == `CBR_PTR_TOP_ZERO);
  assign weWin    = wrCore & (selWin0 | selWin1) & winReach;

  assign memBus.we    = weWin;
  assign memBus.addr  = winPtr[11:0];
  assign memBus.wdata = pwdata[7:0];

  // write data; unimplemented bits are forced low where each register stores it
  // masking on the store means stored unimplemented bits can never turn on
  cbr_byte_t wByte;
  cbr_byte_t flagsWr;

  assign wByte   = pwdata[7:0];
  // software flag bits only
  // timeout and power-down flags stay under hardware control
  assign flagsWr = (flags_q & ~`CBR_FLAGS_SW_MASK)
                 | (wByte & `CBR_FLAGS_SW_MASK);

  // registers cleared by power-on and by warm reset
  // warm reset wins over a write that lands in the same cycle
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      pcl_q  <= `CBR_RST_BYTE;
      p0Hi_q <= `CBR_RST_BYTE;
      p1Hi_q <= `CBR_RST_BYTE;
      bank_q <= `CBR_RST_BYTE;
      pch_q  <= `CBR_RST_BYTE;
      intc_q <= `CBR_RST_BYTE;
    end
    else if (warmReset)
    begin
      pcl_q  <= `CBR_RST_BYTE;
      p0Hi_q <= `CBR_RST_BYTE;
      p1Hi_q <= `CBR_RST_BYTE;
      bank_q <= `CBR_RST_BYTE;
      pch_q  <= `CBR_RST_BYTE;
      intc_q <= `CBR_RST_BYTE;
    end
    else
    begin
      if (wePcl)
        pcl_q  <= wByte;
      if (weP0Hi)
        p0Hi_q <= wByte;
      if (weP1Hi)
        p1Hi_q <= wByte;
      if (weBank)
        bank_q <= wByte & `CBR_BANK_MASK;
      if (wePch)
        pch_q  <= wByte & `CBR_PCH_MASK;
      if (weIntc)
        intc_q <= wByte;
    end
  end

  // registers that survive a warm reset
  // a write in the warm reset cycle is dropped, not deferred
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      p0Lo_q <= `CBR_RST_BYTE;
      p1Lo_q <= `CBR_RST_BYTE;
      wacc_q <= `CBR_RST_BYTE;
    end
    else if (!warmReset)
    begin
      if (weP0Lo)
        p0Lo_q <= wByte;
      if (weP1Lo)
        p1Lo_q <= wByte;
      if (weWacc)
        wacc_q <= wByte;
    end
  end

  // flags: timeout and power-down reloaded from the reset controller
  // the arithmetic flags keep their value across a warm reset
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      flags_q <= `CBR_RST_FLAGS;
    end
    else if (warmReset)
    begin
      flags_q[`CBR_FLAG_TO] <= warmTo;
      flags_q[`CBR_FLAG_PD] <= warmPd;
    end
    else if (weFlags)
    begin
      flags_q <= flagsWr;
    end
  end

  // read selection
  // trade-off: one long priority mux rather than a registered decode,
  // so the read value is ready within the setup cycle
  cbr_byte_t winByte;
  cbr_byte_t coreByte;
  cbr_byte_t readByte;

  assign winByte  = winReach ? memBus.rdata : `CBR_RST_BYTE;
  assign coreByte =
      (selWin0 | selWin1)              ? winByte :
      (bankOff == `CBR_IDX_PCL)        ? pcl_q :
      (bankOff == `CBR_IDX_FLAGS)      ? (flags_q & `CBR_FLAGS_MASK) :
      (bankOff == `CBR_IDX_P0LO)       ? p0Lo_q :
      (bankOff == `CBR_IDX_P0HI)       ? p0Hi_q :
      (bankOff == `CBR_IDX_P1LO)       ? p1Lo_q :
      (bankOff == `CBR_IDX_P1HI)       ? p1Hi_q :
      (bankOff == `CBR_IDX_BANK)       ? (bank_q & `CBR_BANK_MASK) :
      (bankOff == `CBR_IDX_WACC)       ? wacc_q :
      (bankOff == `CBR_IDX_PCH)        ? (pch_q & `CBR_PCH_MASK) :
      intc_q;
  assign readByte = (coreHit & aligned) ? coreByte : `CBR_RST_BYTE;

  // read data is caught in setup so the access phase needs no wait
  // upper lanes stay zero since every register is one byte wide
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      prdata_q <= 32'h0;
    end
    else if (setupPh)
    begin
      prdata_q <= {24'h0, readByte};
    end
  end

  // apb answers
  // an error is only raised for a misaligned word; holes answer quietly
  assign prdata  = prdata_q;
  assign pready  = 1'b1;                   // zero wait states
  assign pslverr = accessPh & ~aligned;    // misaligned word access

  // views for the core
  // masked bits are already zero in the flops, so no mask is needed
  assign pcLow       = pcl_q;
  assign pcHighLatch = pch_q[6:0];
  assign bankSel     = bank_q[4:0];
  assign workAcc     = wacc_q;
  assign intCtrl     = intc_q;
  assign coreFlags   = flags_q[4:0];
  assign ptrZero     = {p0Hi_q, p0Lo_q};
  assign ptrOne      = {p1Hi_q, p1Lo_q};
endmodule // cbr_core_regs
`default_nettype wire

// ---- hw/cbr_data_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module cbr_data_mem (
  // clock
  input wire logic   mclk,
  // access from the register group
  cbr_mem_if.store   mem
);
  import cbr_pkg::*;

  // full 4 KiB data space reached through the indirect windows
  cbr_byte_t store [0:4095];

  // write on the edge, read combinationally so windows need no wait
  always_ff @(posedge mclk)
  begin
    if (mem.we)
    begin
      store[mem.addr] <= mem.wdata;
    end
  end

  assign mem.rdata = store[mem.addr];
endmodule // cbr_data_mem
`default_nettype wire

// ---- shared/cbr_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface cbr_mem_if;
  import cbr_pkg::*;
  logic       we;
  cbr_daddr_t addr;
  cbr_byte_t  wdata;
  cbr_byte_t  rdata;
  modport ctrl  (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface // cbr_mem_if
`default_nettype wire

// ---- shared/cbr_pkg.sv ----
package cbr_pkg;
  typedef logic [7:0]  cbr_byte_t;
  typedef logic [11:0] cbr_daddr_t;
  typedef logic [13:0] cbr_paddr_t;
  typedef logic [15:0] cbr_ptr_t;
  typedef logic [31:0] cbr_word_t;
endpackage

// ---- shared/cbr_regs.svh ----
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH

// register indexes within a bank; byte address on apb is four times these
`define CBR_IDX_WIN0      7'h00
`define CBR_IDX_WIN1      7'h01
`define CBR_IDX_PCL       7'h02
`define CBR_IDX_FLAGS     7'h03
`define CBR_IDX_P0LO      7'h04
`define CBR_IDX_P0HI      7'h05
`define CBR_IDX_P1LO      7'h06
`define CBR_IDX_P1HI      7'h07
`define CBR_IDX_BANK      7'h08
`define CBR_IDX_WACC      7'h09
`define CBR_IDX_PCH       7'h0a
`define CBR_IDX_INTC      7'h0b
// first offset past the core group within a bank
`define CBR_CORE_COUNT    7'h0c

// implemented-bit masks
`define CBR_PCH_MASK      8'h7f
`define CBR_BANK_MASK     8'h1f
`define CBR_FLAGS_MASK    8'h1f
`define CBR_FLAGS_SW_MASK 8'h07

// flag field positions
`define CBR_FLAG_TO       4
`define CBR_FLAG_PD       3

// values on power-on reset; the byte value is also loaded by warm reset
`define CBR_RST_BYTE      8'h00
`define CBR_RST_FLAGS     8'h18

// indirect pointer reach: upper nibble must be zero
`define CBR_PTR_TOP_ZERO  4'h0

`endif
